// ===== sim/adc_fast_threshold_detect_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_fast_threshold_detect_test;
   logic        mclk = 1'b0, srst = 1'b1, sclk = 1'b0, cs_n = 1'b1, sdio_d = 1'b0, rbit, run = 1'b0;
   logic        ovr_in_a = 1'b0, ovr_in_b = 1'b0;
   logic [13:0] sample_a = 14'h0000, sample_b = 14'h0000;
   wire         sdio_o, sdio_oe_n, flag_a, flag_b, ovr_a, ovr_b;
   wire  [7:0]  atten_cnt;
   wire         sdio_w = sdio_oe_n ? sdio_d : sdio_o;
   integer      err_count = 0, n_checks = 0, seed = 32'h7ca0_6a89, mode = 0;
   integer      up = 8191, lo = 0, dw = 1, en = 0, cnt[2];
   logic [1:0]  st;
   logic [6:0]  fp[2];
   logic [35:0] op[2];
   aftd_top u_dut (.mclk, .srst, .sample_a, .sample_b, .ovr_in_a, .ovr_in_b, .sclk, .cs_n, .sdio_i(sdio_w),
      .sdio_o, .sdio_oe_n, .threshold_flag_chan_a(flag_a), .threshold_flag_chan_b(flag_b),
      .overrange_a(ovr_a), .overrange_b(ovr_b));
   aftd_gain_ctl u_gain (.mclk, .srst, .flag_a, .flag_b, .atten_cnt);
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   task chk_bit(input logic e, input logic g);
      n_checks++;
      if (g !== e) begin err_count++; $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g); end
   endtask
   task chk_byte(input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin err_count++; $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g); end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d insertions %0d", n_checks, err_count, atten_cnt);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // each serial level lasts two sample clocks
   task automatic sbit(input logic b);
      sclk = 1'b0; sdio_d = b;
      repeat (2) @(negedge mclk);
      rbit = sdio_w; sclk = 1'b1;
      repeat (2) @(negedge mclk);
   endtask
   task automatic sx(input logic [15:0] ins, input logic [7:0] d[$], output logic [7:0] rd);
      integer i, j;
      rd = 8'h00;
      @(negedge mclk) cs_n = 1'b0;
      @(negedge mclk);
      for (i = 15; i >= 0; i--) sbit(ins[i]);
      for (j = 0; j < d.size(); j++)
         for (i = 7; i >= 0; i--) begin sbit(d[j][i]); rd = {rd[6:0], rbit}; end
      repeat (2) @(negedge mclk);
      sclk = 1'b0; cs_n = 1'b1;
      repeat (4) @(negedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin : model
      integer k, m;
      logic [13:0] s;
      for (k = 0; k < 2; k++) begin
         s = k ? sample_b : sample_a;
         m = s[13] ? 16384 - s : s;
         if (srst || en == 0) begin st[k] = 1'b0; cnt[k] = 0; end
         else if (m > up) begin st[k] = 1'b1; cnt[k] = 0; end
         else if (st[k] && m < lo) begin
            cnt[k]++;
            if (cnt[k] >= (dw ? dw : 1)) begin st[k] = 1'b0; cnt[k] = 0; end
         end else cnt[k] = 0;
         fp[k] = srst ? 7'h00 : {fp[k][5:0], st[k]};
         op[k] = srst ? 36'h0 : {op[k][34:0], k ? ovr_in_b : ovr_in_a};
      end
   end
   always @(negedge mclk) begin : drive
      integer r, m;
      if (cs_n) sdio_d <= ~sdio_d;
      r = $random(seed);
      {ovr_in_a, ovr_in_b} <= r[3:2];
      if (r[5:0] == 6'h00 && (dw < 64 || r[8:6] == 3'h0)) mode = r[10:9];
      m = mode == 0 ? lo / 2 + r[14:11] : mode == 1 ? lo - 1 + r[17:16] % 3 : mode == 2 ? up - 1 + r[17:16] % 3 : r[29:16];
      sample_a <= run ? 14'(r[30] ? -m : m) : 14'h0000;
      sample_b <= run ? 14'(r[31] ? -m : m) : 14'h0000;
   end
   always @(negedge mclk) begin
      if (!srst) begin
         chk_bit(fp[0][6], flag_a);
         chk_bit(fp[1][6], flag_b);
         chk_bit(op[0][35], ovr_a);
         chk_bit(op[1][35], ovr_b);
      end
   end
   // about 13k cycles of work, so 30k means a hang
   initial begin
      repeat (30000) @(posedge mclk);
      err_count++;
      complete_run;
   end
   initial begin : main
      logic [7:0] rd;
      integer a;
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      for (a = 8'h44; a < 8'h4d; a++) begin
         sx(16'h8000 | 16'(a), '{8'h00}, rd);
         chk_byte(a == 8'h47 ? 8'hff : a == 8'h48 ? 8'h1f : a == 8'h4b ? 8'h01 : 8'h00, rd);
      end
      $display("reset values done");
      run = 1'b1; repeat (300) @(negedge mclk); run = 1'b0;
      $display("disabled detect done");
      sx(16'h6045, '{8'h00, 8'h55, 8'hff, 8'hef, 8'h1d, 8'hea, 8'h05, 8'h00}, rd);
      up = 4095; lo = 2589; dw = 5;
      sx(16'h8048, '{8'h00}, rd); chk_byte(8'h0f, rd);
      sx(16'h804a, '{8'h00}, rd); chk_byte(8'h0a, rd);
      sx(16'h8046, '{8'h00}, rd); chk_byte(8'h00, rd);
      sx(16'h0045, '{8'h01}, rd); en = 1;
      run = 1'b1; repeat (3000) @(negedge mclk); run = 1'b0; repeat (40) @(negedge mclk);
      $display("short dwell done");
      sx(16'h004b, '{8'h02, 8'h01}, rd); dw = 258;
      run = 1'b1; repeat (6000) @(negedge mclk); run = 1'b0; repeat (300) @(negedge mclk);
      $display("long dwell done");
      sx(16'h004b, '{8'h00, 8'h00}, rd); dw = 0;
      run = 1'b1; repeat (1000) @(negedge mclk); run = 1'b0;
      $display("zero dwell done");
      complete_run;
   end
endmodule // adc_fast_threshold_detect_test
`default_nettype wire

// ===== sim/aftd_gain_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// gain ranging controller: counts attenuator insertions
module aftd_gain_ctl (
   // clock and reset
   input wire logic  mclk,
   input wire logic  srst,
   // flags in, insertion count out
   input wire logic  flag_a,
   input wire logic  flag_b,
   output logic [7:0] atten_cnt
);
   logic prev_r;
   always_ff @(posedge mclk) begin
      prev_r <= !srst && (flag_a || flag_b);
      if (srst) atten_cnt <= 8'h00;
      else if ((flag_a || flag_b) && !prev_r) atten_cnt <= atten_cnt + 8'h01;
   end
endmodule // aftd_gain_ctl
`default_nettype wire

// ===== sim/aftd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aftd_properties #(
   parameter integer SAMP_W = 14,
   parameter integer UP_LAT = 7,
   parameter integer OR_LAT = 36
) (
   // clock and reset
   input wire logic              mclk,
   input wire logic              srst,
   // samples and raw overrange
   input wire logic [SAMP_W-1:0] sample_a,
   input wire logic [SAMP_W-1:0] sample_b,
   input wire logic              ovr_in_a,
   input wire logic              ovr_in_b,
   // serial port
   input wire logic              sclk,
   input wire logic              cs_n,
   input wire logic              sdio_o,
   input wire logic              sdio_oe_n,
   // flags
   input wire logic              threshold_flag_chan_a,
   input wire logic              threshold_flag_chan_b,
   input wire logic              overrange_a,
   input wire logic              overrange_b
);
   // cycles since reset; delay line holds pre-reset zeros until full
   logic [5:0] up_r;
   always_ff @(posedge mclk) begin
      if (srst) up_r <= 6'h00;
      else if (up_r != 6'h3f) up_r <= up_r + 6'h01;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence sclk_fell_s;
      $past(sclk, 2) && !$past(sclk);
   endsequence
   ovr_delay_a: assert property (up_r >= 6'h28 |-> overrange_a == $past(ovr_in_a, OR_LAT))
      else $error("overrange a delay wrong");
   ovr_delay_b: assert property (up_r >= 6'h28 |-> overrange_b == $past(ovr_in_b, OR_LAT))
      else $error("overrange b delay wrong");
   flag_rise_a: assert property ($rose(threshold_flag_chan_a) |-> $past(sample_a, UP_LAT) != '0)
      else $error("flag a rose without a large sample");
   flag_rise_b: assert property ($rose(threshold_flag_chan_b) |-> $past(sample_b, UP_LAT) != '0)
      else $error("flag b rose without a large sample");
   flag_clear_a: assert property ($fell(threshold_flag_chan_a) |-> $past(sample_a, UP_LAT) != 14'h2000)
      else $error("flag a cleared on full scale");
   rd_timing_a: assert property ($changed(sdio_o) |-> sclk_fell_s)
      else $error("read bit moved off a falling clock");
   oe_start_a: assert property ($fell(sdio_oe_n) |-> sclk_fell_s)
      else $error("output enable early");
   oe_release_a: assert property (cs_n ##1 cs_n |-> sdio_oe_n)
      else $error("output enable held while deselected");
   out_idle_a: assert property ($fell(srst) |-> !threshold_flag_chan_a && !threshold_flag_chan_b
      && !overrange_a && !overrange_b)
      else $error("outputs not idle after reset");
endmodule // aftd_properties
bind aftd_top aftd_properties #(.SAMP_W(SAMP_W), .UP_LAT(UP_LAT), .OR_LAT(OR_LAT)) u_props (
   .mclk, .srst, .sample_a, .sample_b, .ovr_in_a, .ovr_in_b, .sclk, .cs_n, .sdio_o, .sdio_oe_n,
   .threshold_flag_chan_a, .threshold_flag_chan_b, .overrange_a, .overrange_b);
`default_nettype wire

// ===== src/aftd_chan.v
`timescale 1ns/1ps
`default_nettype none
module aftd_chan #(
   parameter integer DW    = 14,
   parameter integer DWL_W = 16,
   parameter integer LAT   = 7
) (
   // clock and reset
   input  wire             mclk,
   input  wire             srst,
   // control
   input  wire             enable,
   input  wire [DW-2:0]    upper_th,
   input  wire [DW-2:0]    lower_th,
   input  wire [DWL_W-1:0] dwell,
   // sample in, flag out
   input  wire [DW-1:0]    sample,
   output wire             flag
);

   localparam ST_IDLE = 1'b0;
   localparam ST_HELD = 1'b1;

   ////////////////////////////////////////////////////////////////
   // sign dropped, -full scale maps to 2^(DW-1) without wrap
   wire [DW-1:0] neg = ~sample + {{(DW-1){1'b0}}, 1'b1};
   wire [DW-1:0] mag = sample[DW-1] ? neg : sample;
   wire          above = (mag > {1'b0, upper_th});
   wire          below = (mag < {1'b0, lower_th});

   // compare results travel LAT-1 stages, the flag register is the last
   reg  [2*(LAT-1)-1:0] cmp_r;
   wire [2*(LAT-1)-1:0] cmp_nxt;
   generate
      if (LAT > 2) begin : g_pipe
         assign cmp_nxt = {cmp_r[2*(LAT-2)-1:0], above, below};
      end else begin : g_one
         assign cmp_nxt = {above, below};
      end
   endgenerate
   wire above_d = cmp_r[2*(LAT-1)-1];
   wire below_d = cmp_r[2*(LAT-1)-2];

   ////////////////////////////////////////////////////////////////
   reg             state_r;
   reg             state_nxt;
   reg [DWL_W-1:0] cnt_r;
   reg [DWL_W-1:0] cnt_nxt;
   wire [DWL_W:0]  cnt_inc = {1'b0, cnt_r} + {{DWL_W{1'b0}}, 1'b1};

   always @* begin
      state_nxt = state_r;
      cnt_nxt   = {DWL_W{1'b0}};
      case (state_r)
         ST_IDLE: begin
            if (enable && above_d) begin
               state_nxt = ST_HELD;
            end
         end
         ST_HELD: begin
            if (!enable) begin
               state_nxt = ST_IDLE;
            end else if (below_d) begin
               // dwell of zero acts as one
               if (cnt_inc >= {1'b0, dwell}) begin
                  state_nxt = ST_IDLE;
               end else begin
                  cnt_nxt = cnt_inc[DWL_W-1:0];
               end
            end else begin
               cnt_nxt = {DWL_W{1'b0}};
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (srst) begin
         cmp_r   <= {2*(LAT-1){1'b0}};
         state_r <= ST_IDLE;
         cnt_r   <= {DWL_W{1'b0}};
      end else begin
         cmp_r   <= cmp_nxt;
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign flag = state_r;

endmodule // aftd_chan
`default_nettype wire

// ===== src/aftd_delay.v
`timescale 1ns/1ps
`default_nettype none
module aftd_delay #(
   parameter integer WIDTH = 2,
   parameter integer DEPTH = 36
) (
   // clock and reset
   input  wire             mclk,
   input  wire             srst,
   // data
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);

   ////////////////////////////////////////////////////////////////
   reg  [WIDTH*DEPTH-1:0] pipe_r;
   wire [WIDTH*DEPTH-1:0] pipe_nxt;

   generate
      if (DEPTH > 1) begin : g_long
         assign pipe_nxt = {pipe_r[WIDTH*(DEPTH-1)-1:0], din};
      end else begin : g_short
         assign pipe_nxt = din;
      end
   endgenerate

   always @(posedge mclk) begin
      if (srst) begin
         pipe_r <= {WIDTH*DEPTH{1'b0}};
      end else begin
         pipe_r <= pipe_nxt;
      end
   end

   assign dout = pipe_r[WIDTH*DEPTH-1 -: WIDTH];

endmodule // aftd_delay
`default_nettype wire

// ===== src/aftd_regs.vh
`ifndef AFTD_REGS_VH
`define AFTD_REGS_VH

// register byte addresses on the serial control port
`define AFTD_ADDR_CTRL     13'h0045
`define AFTD_ADDR_UTH_LO   13'h0047
`define AFTD_ADDR_UTH_HI   13'h0048
`define AFTD_ADDR_LTH_LO   13'h0049
`define AFTD_ADDR_LTH_HI   13'h004A
`define AFTD_ADDR_DWL_LO   13'h004B
`define AFTD_ADDR_DWL_HI   13'h004C
`define AFTD_ADDR_STAT     13'h004D

// field positions
`define AFTD_CTRL_EN_BIT   0
`define AFTD_TH_HI_MSB     4
`define AFTD_INSTR_RW_BIT  15
`define AFTD_INSTR_ADDR_MSB 12

// reset values
`define AFTD_RST_CTRL      8'h00
`define AFTD_RST_UTH_LO    8'hFF
`define AFTD_RST_UTH_HI    5'h1F
`define AFTD_RST_LTH_LO    8'h00
`define AFTD_RST_LTH_HI    5'h00
`define AFTD_RST_DWL_LO    8'h01
`define AFTD_RST_DWL_HI    8'h00

// serial framing
`define AFTD_INSTR_LAST    4'hF
`define AFTD_BYTE_LAST     4'h7
`define AFTD_ADDR_STEP     13'h0001

// latencies in sample clock cycles
`define AFTD_UP_LAT        7
`define AFTD_OR_LAT        36

// sample and dwell widths
`define AFTD_SAMP_W        14
`define AFTD_DWL_W         16

`endif

// ===== src/aftd_top.v
// Notes on behaviour
// - The threshold flags work only while bit 0 of the detect control register is set over the serial port.
// - A threshold flag stays low as long as the sample magnitude is below the selected threshold.
// - Thresholds are compared with the magnitude only, so positive and negative swings act alike.
// - An input overrange shows on the overrange output 36 clock cycles after it occurs.
// - A channel flag rises when the sample magnitude exceeds the upper threshold held in two registers.
// - The upper-threshold flag rises a fixed 7 clock cycles after the compared sample.
// - A raised flag clears after the magnitude stays below the lower threshold for the whole dwell, or at once when detect control bit 0 is cleared.
// - The lower threshold is a 13-bit magnitude split over two registers and compared with the sample magnitude.
// - The dwell is 1 to 65,535 sample clocks, held in two registers.
// - The lower-threshold compare uses full converter resolution and accepts the full pipeline latency.
`timescale 1ns/1ps
`default_nettype none
`include "aftd_regs.vh"
module aftd_top #(
   parameter integer SAMP_W = `AFTD_SAMP_W,
   parameter integer DWL_W  = `AFTD_DWL_W,
   parameter integer UP_LAT = `AFTD_UP_LAT,
   parameter integer OR_LAT = `AFTD_OR_LAT
) (
   // clock and reset
   input  wire              mclk,
   input  wire              srst,
   // converter samples at the pipeline output
   input  wire [SAMP_W-1:0] sample_a,
   input  wire [SAMP_W-1:0] sample_b,
   // raw overrange at the converter input
   input  wire              ovr_in_a,
   input  wire              ovr_in_b,
   // serial control port
   input  wire              sclk,
   input  wire              cs_n,
   input  wire              sdio_i,
   output reg               sdio_o,
   output reg               sdio_oe_n,
   // flags to gain control
   output wire              threshold_flag_chan_a,
   output wire              threshold_flag_chan_b,
   output wire              overrange_a,
   output wire              overrange_b
);

   localparam PH_INSTR = 1'b0;
   localparam PH_DATA  = 1'b1;

   ////////////////////////////////////////////////////////////////
   // register file
   reg  [7:0] ctrl_r;
   reg  [7:0] uth_lo_r;
   reg  [4:0] uth_hi_r;
   reg  [7:0] lth_lo_r;
   reg  [4:0] lth_hi_r;
   reg  [7:0] dwl_lo_r;
   reg  [7:0] dwl_hi_r;

   wire              fd_enable = ctrl_r[`AFTD_CTRL_EN_BIT];
   wire [SAMP_W-2:0] upper_th  = {uth_hi_r, uth_lo_r};
   wire [SAMP_W-2:0] lower_th  = {lth_hi_r, lth_lo_r};
   wire [DWL_W-1:0]  dwell     = {dwl_hi_r, dwl_lo_r};

   ////////////////////////////////////////////////////////////////
   // serial port: pins treated as synchronous, edges found by one-cycle history
   reg         sclk_d_r;
   reg         phase_r;
   reg         phase_nxt;
   reg  [3:0]  bcnt_r;
   reg  [3:0]  bcnt_nxt;
   reg  [14:0] sh_r;
   reg  [14:0] sh_nxt;
   reg         rd_r;
   reg         rd_nxt;
   reg  [12:0] addr_r;
   reg  [12:0] addr_nxt;
   reg  [7:0]  out_r;
   reg  [7:0]  out_nxt;
   reg         sdio_nxt;
   reg         sdio_oe_n_nxt;
   reg         wr_en;
   reg  [7:0]  rd_data;
   reg  [12:0] rd_addr;

   wire        sel      = ~cs_n;
   wire        sclk_re  = sel & sclk & ~sclk_d_r;
   wire        sclk_fe  = sel & ~sclk & sclk_d_r;
   wire [15:0] word_in  = {sh_r, sdio_i};
   wire [12:0] addr_new = word_in[`AFTD_INSTR_ADDR_MSB:0];
   wire [12:0] addr_inc = addr_r + `AFTD_ADDR_STEP;

   ////////////////////////////////////////////////////////////////
   // flags and overrange
   wire [1:0] flags;
   wire [1:0] ovr_d;

   ////////////////////////////////////////////////////////////////
   // readback mux; unmapped addresses return zero
   always @* begin
      if (phase_r == PH_INSTR) begin
         rd_addr = addr_new;
      end else begin
         rd_addr = addr_inc;
      end
      case (rd_addr)
         `AFTD_ADDR_CTRL: begin
            rd_data = ctrl_r;
         end
         `AFTD_ADDR_UTH_LO: begin
            rd_data = uth_lo_r;
         end
         `AFTD_ADDR_UTH_HI: begin
            rd_data = {3'h0, uth_hi_r};
         end
         `AFTD_ADDR_LTH_LO: begin
            rd_data = lth_lo_r;
         end
         `AFTD_ADDR_LTH_HI: begin
            rd_data = {3'h0, lth_hi_r};
         end
         `AFTD_ADDR_DWL_LO: begin
            rd_data = dwl_lo_r;
         end
         `AFTD_ADDR_DWL_HI: begin
            rd_data = dwl_hi_r;
         end
         `AFTD_ADDR_STAT: begin
            // live view of the block outputs
            rd_data = {4'h0, ovr_d, flags};
         end
         default: begin
            rd_data = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // framing: 16-bit instruction, then bytes streamed until cs_n rises
   always @* begin
      phase_nxt     = phase_r;
      bcnt_nxt      = bcnt_r;
      sh_nxt        = sh_r;
      rd_nxt        = rd_r;
      addr_nxt      = addr_r;
      out_nxt       = out_r;
      sdio_nxt      = sdio_o;
      sdio_oe_n_nxt = sdio_oe_n;
      wr_en         = 1'b0;
      if (!sel) begin
         // deselect aborts any partial byte
         phase_nxt     = PH_INSTR;
         bcnt_nxt      = 4'h0;
         sdio_oe_n_nxt = 1'b1;
      end else if (sclk_re) begin
         sh_nxt   = word_in[14:0];
         bcnt_nxt = bcnt_r + 4'h1;
         case (phase_r)
            PH_INSTR: begin
               if (bcnt_r == `AFTD_INSTR_LAST) begin
                  rd_nxt    = word_in[`AFTD_INSTR_RW_BIT];
                  addr_nxt  = addr_new;
                  out_nxt   = rd_data;
                  phase_nxt = PH_DATA;
                  bcnt_nxt  = 4'h0;
               end
            end
            PH_DATA: begin
               if (bcnt_r == `AFTD_BYTE_LAST) begin
                  wr_en    = ~rd_r;
                  addr_nxt = addr_inc;
                  out_nxt  = rd_data;
                  bcnt_nxt = 4'h0;
               end
            end
            default: begin
               phase_nxt = PH_INSTR;
            end
         endcase
      end else if (sclk_fe && phase_r == PH_DATA && rd_r) begin
         // readback leaves on falling edges, msb first
         sdio_nxt      = out_r[7];
         out_nxt       = {out_r[6:0], 1'b0};
         sdio_oe_n_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (srst) begin
         sclk_d_r  <= 1'b0;
         phase_r   <= PH_INSTR;
         bcnt_r    <= 4'h0;
         sh_r      <= 15'h0000;
         rd_r      <= 1'b0;
         addr_r    <= 13'h0000;
         out_r     <= 8'h00;
         sdio_o    <= 1'b0;
         sdio_oe_n <= 1'b1;
      end else begin
         sclk_d_r  <= sclk;
         phase_r   <= phase_nxt;
         bcnt_r    <= bcnt_nxt;
         sh_r      <= sh_nxt;
         rd_r      <= rd_nxt;
         addr_r    <= addr_nxt;
         out_r     <= out_nxt;
         sdio_o    <= sdio_nxt;
         sdio_oe_n <= sdio_oe_n_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // register writes land on the rising edge of the last data bit
   always @(posedge mclk) begin
      if (srst) begin
         ctrl_r   <= `AFTD_RST_CTRL;
         uth_lo_r <= `AFTD_RST_UTH_LO;
         uth_hi_r <= `AFTD_RST_UTH_HI;
         lth_lo_r <= `AFTD_RST_LTH_LO;
         lth_hi_r <= `AFTD_RST_LTH_HI;
         dwl_lo_r <= `AFTD_RST_DWL_LO;
         dwl_hi_r <= `AFTD_RST_DWL_HI;
      end else if (wr_en) begin
         case (addr_r)
            `AFTD_ADDR_CTRL: begin
               ctrl_r <= word_in[7:0];
            end
            `AFTD_ADDR_UTH_LO: begin
               uth_lo_r <= word_in[7:0];
            end
            `AFTD_ADDR_UTH_HI: begin
               uth_hi_r <= word_in[`AFTD_TH_HI_MSB:0];
            end
            `AFTD_ADDR_LTH_LO: begin
               lth_lo_r <= word_in[7:0];
            end
            `AFTD_ADDR_LTH_HI: begin
               lth_hi_r <= word_in[`AFTD_TH_HI_MSB:0];
            end
            `AFTD_ADDR_DWL_LO: begin
               dwl_lo_r <= word_in[7:0];
            end
            `AFTD_ADDR_DWL_HI: begin
               dwl_hi_r <= word_in[7:0];
            end
            default: begin
               ctrl_r <= ctrl_r;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // per-channel detectors share one set of thresholds
   aftd_chan #(
      .DW    (SAMP_W),
      .DWL_W (DWL_W),
      .LAT   (UP_LAT)
   ) u_chan_a (
      .mclk     (mclk),
      .srst     (srst),
      .enable   (fd_enable),
      .upper_th (upper_th),
      .lower_th (lower_th),
      .dwell    (dwell),
      .sample   (sample_a),
      .flag     (flags[0])
   );

   aftd_chan #(
      .DW    (SAMP_W),
      .DWL_W (DWL_W),
      .LAT   (UP_LAT)
   ) u_chan_b (
      .mclk     (mclk),
      .srst     (srst),
      .enable   (fd_enable),
      .upper_th (upper_th),
      .lower_th (lower_th),
      .dwell    (dwell),
      .sample   (sample_b),
      .flag     (flags[1])
   );

   ////////////////////////////////////////////////////////////////
   // overrange follows the full pipeline, not gated by the detect enable
   aftd_delay #(
      .WIDTH (2),
      .DEPTH (OR_LAT)
   ) u_ovr_dly (
      .mclk (mclk),
      .srst (srst),
      .din  ({ovr_in_b, ovr_in_a}),
      .dout (ovr_d)
   );

   assign threshold_flag_chan_a = flags[0];
   assign threshold_flag_chan_b = flags[1];
   assign overrange_a           = ovr_d[0];
   assign overrange_b           = ovr_d[1];

endmodule // aftd_top
`default_nettype wire
